// >>> pld_pkg.sv
package pld_pkg;
   localparam int NUM_MC = 10;
   localparam int NUM_IN = 12;
   localparam int NUM_SIG = NUM_IN + NUM_MC;
   localparam int LIT_W = 2 * NUM_SIG;
   localparam int FUSE_HI_W = LIT_W - 32;
   localparam int OE_BASE = 120;
   localparam int AR_IDX = 130;
   localparam int SP_IDX = 131;
   localparam int NUM_TERMS = 132;
   localparam logic [LIT_W-1:0] FUSE_ERASED = 44'hFFF_FFFF_FFFF;

   localparam int ADDR_W = 12;
   localparam logic [11:0] SIG_OFS = 12'h000;
   localparam logic [11:0] GCFG_OFS = 12'h004;
   localparam logic [11:0] MCCFG_OFS = 12'h008;
   localparam logic [11:0] MCCFG_END = 12'h030;
   localparam logic [11:0] STAT_OFS = 12'h040;
   localparam logic [11:0] FUSE_OFS = 12'h400;
   localparam logic [11:0] FUSE_END = 12'h820;

   localparam logic [1:0] TERM_KEEPER = 2'h0;
   localparam logic [1:0] TERM_PULLUP = 2'h1;
   localparam logic [1:0] TERM_PULLDN = 2'h2;
   localparam logic [1:0] TERM_NONE = 2'h3;
   localparam logic [1:0] GCFG_RST = TERM_PULLUP;

   localparam int MC_POL_BIT = 0;
   localparam int MC_MODE_BIT = 1;
   localparam int MC_OE_LSB = 2;
   localparam int MC_SLEW_BIT = 4;
   localparam int MC_OD_BIT = 5;
   localparam int MC_CFG_W = 6;
   localparam logic [5:0] MC_CFG_RST = 6'h00;
   localparam logic [31:0] SIG_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      OE_TERM = 2'h0,
      OE_ON = 2'h1,
      OE_OFF = 2'h2
   } oe_mode_e;

   localparam int ST_PIN_LSB = 10;
   localparam int ST_AR_BIT = 20;
   localparam int ST_SP_BIT = 21;
   localparam int ST_POR_BIT = 22;

   localparam int TPR_NS = 1000;
   localparam int CLK_NS = 100;
   localparam logic [3:0] TPR_CYC = 4'(TPR_NS / CLK_NS);

   localparam int IR_W = 4;
   localparam logic [3:0] IR_EXTEST = 4'h0;
   localparam logic [3:0] IR_SAMPLE = 4'h2;
   localparam logic [3:0] IR_USERCODE = 4'h8;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_CAPT = 4'h1;
   localparam int BSR_W = 42;
   localparam int BSR_PIN_LSB = 12;
   localparam int BSR_OUT_LSB = 22;
   localparam int BSR_OE_LSB = 32;

   typedef enum logic [3:0] {
      TAP_TLR = 4'hF, TAP_RTI = 4'hC, TAP_SELDR = 4'h7,
      TAP_CAPDR = 4'h6, TAP_SHDR = 4'h2, TAP_EX1DR = 4'h1,
      TAP_PSDR = 4'h3, TAP_EX2DR = 4'h0, TAP_UPDR = 4'h5,
      TAP_SELIR = 4'h4, TAP_CAPIR = 4'hE, TAP_SHIR = 4'hA,
      TAP_EX1IR = 4'h9, TAP_PSIR = 4'hB, TAP_EX2IR = 4'h8,
      TAP_UPIR = 4'hD
   } tap_state_e;

   function automatic int mc_term_cnt(input int m);
      return 8 + 2 * (m / 2);
   endfunction

   function automatic int mc_term_base(input int m);
      int p;
      p = m / 2;
      return 16 * p + 2 * p * (p - 1) + (m % 2) * mc_term_cnt(m);
   endfunction
endpackage

// >>> programmable_macrocell_array.sv
`timescale 1ns/1ps
// What this block does
// - Ten macrocells, pairs of 8/10/12/14/16 terms.
// - One extra enable term per macrocell.
// - Per-macrocell true or inverted output polarity.
// - Shared clear term zeroes flip-flops at once.
// - Shared preset term sets flip-flops next edge.
// - Clear and preset ignore output polarity.
// - Two config bits select mode and polarity.
// - Registered pin driven from flip-flop state.
// - Registered feedback from inverted flip-flop output.
// - Registered pin level never feeds array.
// - Registered enable from own enable term.
// - Combinatorial pin driven by sum directly.
// - Combinatorial enable on, off or term.
// - Combinatorial feedback taken from pin level.
// - Reprogrammable 32-bit user signature, always readable.
// - Scan user-code instruction reads the signature.
// - One global four-way input termination choice.
// - Termination defaults to pull-up.
// - Per-output fast or slow edge bit.
// - Per-output open-drain option, drives low only.
// - Boundary-scan cells with capture, shift, update.
// - Power-up clears all flip-flops within interval.
module programmable_macrocell_array (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Avalon-MM register slave.
   input wire logic [pld_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Board pins.
   input wire logic [pld_pkg::NUM_IN-1:0] ded_in_i,
   input wire logic [pld_pkg::NUM_MC-1:0] io_i,
   output logic [pld_pkg::NUM_MC-1:0] io_o,
   output logic [pld_pkg::NUM_MC-1:0] io_oe_n_o,
   output logic [pld_pkg::NUM_MC-1:0] slew_fast_o,
   output logic [1:0] term_sel_o,
   // Test access port.
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_n_o
);
   import pld_pkg::*;

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic in_range(input logic [11:0] a,
                                     input logic [11:0] lo,
                                     input logic [11:0] hi);
      return (a >= lo) && (a < hi);
   endfunction

   function automatic tap_state_e tap_next(input tap_state_e s,
                                           input logic tms);
      case (s)
         TAP_TLR: tap_next = tms ? TAP_TLR : TAP_RTI;
         TAP_RTI: tap_next = tms ? TAP_SELDR : TAP_RTI;
         TAP_SELDR: tap_next = tms ? TAP_SELIR : TAP_CAPDR;
         TAP_CAPDR: tap_next = tms ? TAP_EX1DR : TAP_SHDR;
         TAP_SHDR: tap_next = tms ? TAP_EX1DR : TAP_SHDR;
         TAP_EX1DR: tap_next = tms ? TAP_UPDR : TAP_PSDR;
         TAP_PSDR: tap_next = tms ? TAP_EX2DR : TAP_PSDR;
         TAP_EX2DR: tap_next = tms ? TAP_UPDR : TAP_SHDR;
         TAP_UPDR: tap_next = tms ? TAP_SELDR : TAP_RTI;
         TAP_SELIR: tap_next = tms ? TAP_TLR : TAP_CAPIR;
         TAP_CAPIR: tap_next = tms ? TAP_EX1IR : TAP_SHIR;
         TAP_SHIR: tap_next = tms ? TAP_EX1IR : TAP_SHIR;
         TAP_EX1IR: tap_next = tms ? TAP_UPIR : TAP_PSIR;
         TAP_PSIR: tap_next = tms ? TAP_EX2IR : TAP_PSIR;
         TAP_EX2IR: tap_next = tms ? TAP_UPIR : TAP_SHIR;
         TAP_UPIR: tap_next = tms ? TAP_SELDR : TAP_RTI;
         default: tap_next = TAP_TLR;
      endcase
   endfunction

   logic [LIT_W-1:0] fuse_reg [NUM_TERMS];
   logic [31:0] sig_reg;
   logic [1:0] gcfg_reg;
   logic [MC_CFG_W-1:0] mccfg_reg [NUM_MC];
   logic [NUM_MC-1:0] q_reg;
   logic [3:0] por_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [NUM_SIG-1:0] sig_vec;
   logic [LIT_W-1:0] lit;
   logic [NUM_TERMS-1:0] pt;
   logic [NUM_MC-1:0] sum;
   logic [NUM_MC-1:0] fb;
   logic [NUM_MC-1:0] q_vis;
   logic [NUM_MC-1:0] core_val;
   logic [NUM_MC-1:0] core_en;
   logic [NUM_MC-1:0] pin_val;
   logic [NUM_MC-1:0] pin_en;
   logic [NUM_MC-1:0] od;
   logic ar_term;
   logic sp_term;
   logic por_busy;
   logic bus_req;
   logic wr_fire;
   logic [11:0] fuse_off;
   logic [31:0] fuse_hi_mrg;
   logic [7:0] fuse_idx;
   logic [3:0] mc_idx;
   logic [11:0] mc_off;
   logic [31:0] rd_mux;
   tap_state_e tap_reg;
   logic tck_reg;
   logic tck_rise;
   logic tck_fall;
   logic [IR_W-1:0] ir_sh_reg;
   logic [IR_W-1:0] ir_reg;
   logic [BSR_W-1:0] dr_reg;
   logic [BSR_W-1:0] bsr_upd_reg;
   logic extest;

   // Product-term array: a set fuse connects a literal; an erased row
   // holds both polarities of every signal and so evaluates to zero.
   assign sig_vec = {fb, ded_in_i};
   genvar k;
   generate
      for (k = 0; k < NUM_SIG; k++) begin : g_lit
         assign lit[2*k] = sig_vec[k];
         assign lit[2*k+1] = ~sig_vec[k];
      end
      for (k = 0; k < NUM_TERMS; k++) begin : g_pt
         assign pt[k] = &(lit | ~fuse_reg[k]);
      end
   endgenerate

   assign ar_term = pt[AR_IDX];
   assign sp_term = pt[SP_IDX];
   assign por_busy = (por_reg != 4'h0);
   assign extest = (ir_reg == IR_EXTEST);

   generate
      for (k = 0; k < NUM_MC; k++) begin : g_mc
         localparam int B = mc_term_base(k);
         localparam int C = mc_term_cnt(k);
         logic comb;
         logic pol;
         oe_mode_e oem;
         assign comb = mccfg_reg[k][MC_MODE_BIT];
         assign pol = mccfg_reg[k][MC_POL_BIT];
         assign oem = oe_mode_e'(mccfg_reg[k][MC_OE_LSB +: 2]);
         assign sum[k] = |pt[B +: C];
         // Registered cells feed back the inverted flop output only.
         assign fb[k] = comb ? io_i[k] : ~q_reg[k];
         // Pin level follows polarity; flop state itself does not.
         assign core_val[k] = pol ? (comb ? sum[k] : q_vis[k])
                                  : ~(comb ? sum[k] : q_vis[k]);
         always_comb begin
            if (!comb) begin
               core_en[k] = pt[OE_BASE + k];
            end else begin
               case (oem)
                  OE_ON: core_en[k] = 1'b1;
                  OE_OFF: core_en[k] = 1'b0;
                  default: core_en[k] = pt[OE_BASE + k];
               endcase
            end
         end
         assign od[k] = mccfg_reg[k][MC_OD_BIT];
         assign slew_fast_o[k] = mccfg_reg[k][MC_SLEW_BIT];
      end
   endgenerate

   // Clear masks the state at once, before any clock edge.
   assign q_vis = ar_term ? '0 : q_reg;

   // The AND array sees the unmasked state so the clear term cannot
   // form a loop through its own feedback.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q_reg <= '0;
      end else if (por_busy || ar_term) begin
         q_reg <= '0;
      end else if (sp_term) begin
         q_reg <= '1;
      end else begin
         q_reg <= sum;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         por_reg <= TPR_CYC;
      end else if (por_busy) begin
         por_reg <= por_reg - 4'h1;
      end
   end

   // Pin drivers, with the scan update register taking over in EXTEST.
   assign pin_val = extest ? bsr_upd_reg[BSR_OUT_LSB +: NUM_MC] : core_val;
   assign pin_en = extest ? bsr_upd_reg[BSR_OE_LSB +: NUM_MC] : core_en;
   assign io_o = pin_val & ~od;
   assign io_oe_n_o = ~(pin_en & (~od | ~pin_val));
   assign term_sel_o = gcfg_reg;

   // Register slave: every access waits exactly one cycle.
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & ~ack_reg;
   assign wr_fire = avs_write_i & ack_reg;
   assign avs_readdata_o = rdata_reg;
   assign fuse_off = avs_address_i - FUSE_OFS;
   assign fuse_idx = fuse_off[10:3];
   assign mc_off = avs_address_i - MCCFG_OFS;
   assign mc_idx = mc_off[5:2];
   assign fuse_hi_mrg = be_merge({20'h00000, fuse_reg[fuse_idx][LIT_W-1:32]},
                                 avs_writedata_i, avs_byteenable_i);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (avs_address_i[11:2] == SIG_OFS[11:2]) begin
         rd_mux = sig_reg;
      end else if (avs_address_i[11:2] == GCFG_OFS[11:2]) begin
         rd_mux[1:0] = gcfg_reg;
      end else if (in_range(avs_address_i, MCCFG_OFS, MCCFG_END)) begin
         rd_mux[MC_CFG_W-1:0] = mccfg_reg[mc_idx];
      end else if (avs_address_i[11:2] == STAT_OFS[11:2]) begin
         rd_mux[NUM_MC-1:0] = q_vis;
         rd_mux[ST_PIN_LSB +: NUM_MC] = io_i;
         rd_mux[ST_AR_BIT] = ar_term;
         rd_mux[ST_SP_BIT] = sp_term;
         rd_mux[ST_POR_BIT] = por_busy;
      end else if (in_range(avs_address_i, FUSE_OFS, FUSE_END)) begin
         if (fuse_off[2]) begin
            rd_mux[FUSE_HI_W-1:0] = fuse_reg[fuse_idx][LIT_W-1:32];
         end else begin
            rd_mux = fuse_reg[fuse_idx][31:0];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read_i && !ack_reg) begin
         rdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sig_reg <= SIG_RST;
         gcfg_reg <= GCFG_RST;
      end else if (wr_fire) begin
         if (avs_address_i[11:2] == SIG_OFS[11:2]) begin
            sig_reg <= be_merge(sig_reg, avs_writedata_i,
                                avs_byteenable_i);
         end
         if (avs_address_i[11:2] == GCFG_OFS[11:2] &&
             avs_byteenable_i[0]) begin
            gcfg_reg <= avs_writedata_i[1:0];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_MC; i++) begin
            mccfg_reg[i] <= MC_CFG_RST;
         end
      end else if (wr_fire && avs_byteenable_i[0] &&
                   in_range(avs_address_i, MCCFG_OFS, MCCFG_END)) begin
         mccfg_reg[mc_idx] <= avs_writedata_i[MC_CFG_W-1:0];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_TERMS; i++) begin
            fuse_reg[i] <= FUSE_ERASED;
         end
      end else if (wr_fire &&
                   in_range(avs_address_i, FUSE_OFS, FUSE_END)) begin
         if (fuse_off[2]) begin
            fuse_reg[fuse_idx][LIT_W-1:32] <=
               fuse_hi_mrg[FUSE_HI_W-1:0];
         end else begin
            fuse_reg[fuse_idx][31:0] <=
               be_merge(fuse_reg[fuse_idx][31:0], avs_writedata_i,
                        avs_byteenable_i);
         end
      end
   end

   // Test access port: TCK is sampled, so it must be slower than
   // half the system clock.
   assign tck_rise = tck_i & ~tck_reg;
   assign tck_fall = ~tck_i & tck_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tck_reg <= 1'b0;
      end else begin
         tck_reg <= tck_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tap_reg <= TAP_TLR;
      end else if (tck_rise) begin
         tap_reg <= tap_next(tap_reg, tms_i);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ir_sh_reg <= IR_CAPT;
      end else if (tck_rise) begin
         if (tap_reg == TAP_CAPIR) begin
            ir_sh_reg <= IR_CAPT;
         end else if (tap_reg == TAP_SHIR) begin
            ir_sh_reg <= {tdi_i, ir_sh_reg[IR_W-1:1]};
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ir_reg <= IR_BYPASS;
      end else if (tap_reg == TAP_TLR) begin
         ir_reg <= IR_BYPASS;
      end else if (tck_fall && tap_reg == TAP_UPIR) begin
         ir_reg <= ir_sh_reg;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dr_reg <= '0;
      end else if (tck_rise && tap_reg == TAP_CAPDR) begin
         if (ir_reg == IR_USERCODE) begin
            dr_reg <= {10'h000, sig_reg};
         end else if (ir_reg == IR_SAMPLE || extest) begin
            dr_reg <= {core_en, core_val, io_i, ded_in_i};
         end else begin
            dr_reg <= '0;
         end
      end else if (tck_rise && tap_reg == TAP_SHDR) begin
         if (ir_reg == IR_USERCODE) begin
            dr_reg[31:0] <= {tdi_i, dr_reg[31:1]};
         end else if (ir_reg == IR_SAMPLE || extest) begin
            dr_reg <= {tdi_i, dr_reg[BSR_W-1:1]};
         end else begin
            dr_reg[0] <= tdi_i;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bsr_upd_reg <= '0;
      end else if (tck_fall && tap_reg == TAP_UPDR &&
                   (ir_reg == IR_SAMPLE || extest)) begin
         bsr_upd_reg <= dr_reg;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tdo_o <= 1'b0;
         tdo_oe_n_o <= 1'b1;
      end else if (tck_fall) begin
         tdo_o <= (tap_reg == TAP_SHIR) ? ir_sh_reg[0] : dr_reg[0];
         tdo_oe_n_o <= ~(tap_reg == TAP_SHIR || tap_reg == TAP_SHDR);
      end
   end
endmodule

// >>> pld_array_props.sv
`timescale 1ns/1ps
module pld_array_props (
   // Clock and reset.
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register bus.
   input wire logic [pld_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Pins.
   input wire logic [pld_pkg::NUM_MC-1:0] io_i,
   input wire logic [pld_pkg::NUM_MC-1:0] io_o,
   input wire logic [pld_pkg::NUM_MC-1:0] io_oe_n_o,
   input wire logic [pld_pkg::NUM_MC-1:0] slew_fast_o,
   input wire logic [1:0] term_sel_o
);
   import pld_pkg::*;
   wire logic [11:0] wa = {avs_address_i[11:2], 2'h0};
   wire logic req = avs_read_i || avs_write_i;
   wire logic wr_ok = avs_write_i && !avs_waitrequest_o;
   wire logic unmapped = (wa >= MCCFG_END && wa < STAT_OFS) ||
      (wa > STAT_OFS && wa < FUSE_OFS) || wa >= FUSE_END;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence acc_wait;
      req && avs_waitrequest_o;
   endsequence
   sequence rd_done;
      avs_read_i && !avs_waitrequest_o;
   endsequence
   chk_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
      else $error("bus request not held off in its first cycle");
   chk_wait_one: assert property (acc_wait |=> !avs_waitrequest_o)
      else $error("bus access took more than one wait cycle");
   chk_wait_idle: assert property (!req |-> !avs_waitrequest_o)
      else $error("waitrequest high without a request");
   chk_unmapped_zero: assert property (rd_done ##0 unmapped
      |-> avs_readdata_o == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   chk_term_read: assert property (rd_done ##0 (wa == GCFG_OFS)
      |-> avs_readdata_o[1:0] == term_sel_o)
      else $error("termination read differs from its output");
   chk_term_write: assert property ($changed(term_sel_o)
      |-> $past(wr_ok && avs_byteenable_i[0] && wa == GCFG_OFS))
      else $error("termination changed without a write");
   chk_slew_write: assert property ($changed(slew_fast_o)
      |-> $past(wr_ok && wa >= MCCFG_OFS && wa < MCCFG_END))
      else $error("slew changed without a config write");
   chk_status_pins: assert property (rd_done ##0 (wa == STAT_OFS)
      |-> avs_readdata_o[19:10] == $past(io_i))
      else $error("status pin field differs from pin levels");
   chk_clear_q: assert property (rd_done ##0 (wa == STAT_OFS)
      ##0 avs_readdata_o[20] |-> avs_readdata_o[9:0] == 10'h000)
      else $error("flip-flop set while clear term asserted");
   chk_powerup_q: assert property (rd_done ##0 (wa == STAT_OFS)
      ##0 avs_readdata_o[22] |-> avs_readdata_o[9:0] == 10'h000)
      else $error("flip-flop set during power-up clear");
   chk_reset_vals: assert property ($rose(rst_n_i) |-> term_sel_o ==
      TERM_PULLUP && io_oe_n_o == 10'h3FF && io_o == 10'h3FF)
      else $error("pins not at reset levels after reset");
endmodule

bind programmable_macrocell_array pld_array_props u_props (.mclk_i,
   .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
   .avs_readdata_o, .avs_waitrequest_o, .io_i, .io_o, .io_oe_n_o,
   .slew_fast_o, .term_sel_o);

// >>> board_pins_model.sv
`timescale 1ns/1ps
module board_pins_model (
   // Clock.
   input wire logic mclk_i,
   // Device side.
   input wire logic [1:0] term_sel_i,
   input wire logic [9:0] pin_val_i,
   input wire logic [9:0] pin_oe_n_i,
   // Board drivers.
   input wire logic [9:0] ext_en_i,
   input wire logic [9:0] ext_val_i,
   // Level seen on each pin.
   output logic [9:0] io_level_o
);
   logic [9:0] keep_reg = 10'h000;
   logic [9:0] noise_reg = 10'h155;
   always_ff @(posedge mclk_i) begin
      keep_reg <= io_level_o;
      noise_reg <= ~noise_reg;
   end
   // A floating pin with no termination wanders every cycle.
   always_comb begin
      for (int k = 0; k < 10; k++) begin
         if (!pin_oe_n_i[k]) begin
            io_level_o[k] = pin_val_i[k];
         end else if (ext_en_i[k]) begin
            io_level_o[k] = ext_val_i[k];
         end else begin
            case (term_sel_i)
               2'h0: io_level_o[k] = keep_reg[k];
               2'h1: io_level_o[k] = 1'b1;
               2'h2: io_level_o[k] = 1'b0;
               default: io_level_o[k] = noise_reg[k];
            endcase
         end
      end
   end
endmodule

// >>> test_programmable_macrocell_array.sv
`timescale 1ns/1ps
module test_programmable_macrocell_array;
   import pld_pkg::*;
   localparam logic [17:0] TMS_SEQ = 18'h0E0DF;
   localparam logic [17:0] TDI_SEQ = 18'h02000;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [11:0] avs_address_i = 12'h000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [11:0] ded_in_i = 12'h000;
   logic [9:0] io_i, io_o, io_oe_n_o, slew_fast_o;
   logic [1:0] term_sel_o;
   logic tck_i = 1'b0, tms_i = 1'b1, tdi_i = 1'b0, tdo_o, tdo_oe_n_o;
   logic [9:0] ext_en = 10'h000, ext_val = 10'h000;
   int fail_count = 0, comparisons = 0, cyc = 0, seed = 32'hF7DF, base;
   int cnt_t[10] = '{8, 8, 10, 10, 12, 12, 14, 14, 16, 16};
   logic [31:0] rd, sig;
   logic [5:0] cfg;
   logic b;
   logic [2:0] seen;

   always #50 mclk_i = ~mclk_i;

   programmable_macrocell_array DUT (.mclk_i, .rst_n_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
      .avs_readdata_o, .avs_waitrequest_o, .ded_in_i, .io_i, .io_o,
      .io_oe_n_o, .slew_fast_o, .term_sel_o, .tck_i, .tms_i, .tdi_i, .tdo_o,
      .tdo_oe_n_o);
   board_pins_model u_board (.mclk_i, .term_sel_i(term_sel_o),
      .pin_val_i(io_o), .pin_oe_n_i(io_oe_n_o), .ext_en_i(ext_en),
      .ext_val_i(ext_val), .io_level_o(io_i));

   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task chk(input string what, input logic [43:0] exp, input logic [43:0] got);
      comparisons++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] be);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task rdr(input logic [11:0] a);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask

   task fuse(input int t, input logic [43:0] v);
      wr(12'(FUSE_OFS + 8 * t), v[31:0]);
      wr(12'(FUSE_OFS + 8 * t + 4), {20'h0, v[43:32]});
   endtask

   // TMS and TDI move with the falling TCK; TDO is taken late in low phase.
   task tck_cyc(input logic ms, input logic di);
      tck_i <= 1'b0;
      tms_i <= ms;
      tdi_i <= di;
      repeat (3) @(posedge mclk_i);
      b = tdo_o;
      tck_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
   endtask

   function logic [43:0] lit(input int k);
      return 44'h1 << k;
   endfunction

   function logic pin_val(input logic v, input logic pol);
      return pol ? v : ~v;
   endfunction

   function logic [1:0] oe_exp(input int om, input logic d);
      case (om)
         1: return {1'b0, d};
         2: return {1'b1, d};
         4: return {d, 1'b0};
         default: return {~d, d};
      endcase
   endfunction

   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         end_sim;
      end
   end

   initial begin
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      rdr(STAT_OFS);
      chk("powerup status", 44'h400, 44'({rd[22], rd[9:0]}));
      chk("reset pins", 44'hFFFFF, 44'({io_o, io_oe_n_o}));
      rdr(SIG_OFS);
      chk("signature reset", 44'(SIG_RST), 44'(rd));
      rdr(GCFG_OFS);
      chk("termination reset", 44'h1, 44'(rd[1:0]));
      repeat (12) @(posedge mclk_i);
      rdr(STAT_OFS);
      chk("busy cleared", 44'h0, 44'(rd[22]));
      wr(12'h034, 32'hFFFF_FFFF);
      rdr(12'h034);
      chk("unmapped", 44'h0, 44'(rd));
      for (int v = 0; v < 4; v++) begin
         wr(GCFG_OFS, 32'(v));
         chk("term_sel", 44'(v), 44'(term_sel_o));
         if (v == 1 || v == 2) begin
            chk("pulled pin", 44'(v == 1), 44'(io_i[9]));
         end
      end
      bus(1'b1, GCFG_OFS, 32'h0, 4'h0);
      chk("masked write", 44'h3, 44'(term_sel_o));
      wr(GCFG_OFS, 32'(TERM_PULLUP));
      base = 0;
      for (int m = 0; m < 10; m++) begin
         base += cnt_t[m];
         fuse(base - 1, lit(2 * m));
         cfg = {1'b0, 1'($random(seed)), 2'h1, 1'b1, 1'($random(seed))};
         wr(12'(MCCFG_OFS + 4 * m), 32'(cfg));
         rdr(12'(MCCFG_OFS + 4 * m));
         chk("config", 44'(cfg), 44'(rd[5:0]));
         ded_in_i <= 12'($random(seed));
         @(posedge mclk_i);
         seen = {io_oe_n_o[m], slew_fast_o[m], io_o[m]};
         chk("comb pin", 44'({1'b0, cfg[4], pin_val(ded_in_i[m], cfg[0])}),
             44'(seen));
      end
      fuse(OE_BASE, lit(22));
      for (int om = 0; om < 5; om++) begin
         wr(MCCFG_OFS, om < 4 ? 32'({om[1:0], 2'h3}) : 32'h27);
         for (int d = 0; d < 2; d++) begin
            ded_in_i <= {d[0], 10'h000, d[0]};
            @(posedge mclk_i);
            chk("enable", 44'(oe_exp(om, d[0])),
                44'({io_oe_n_o[0], io_o[0]}));
         end
      end
      wr(MCCFG_OFS, 32'h0B);
      fuse(15, lit(25));
      wr(12'h00C, 32'h07);
      ext_en <= 10'h001;
      for (int d = 0; d < 2; d++) begin
         ext_val <= 10'(d);
         @(posedge mclk_i);
         chk("pin feedback", 44'(!d), 44'(io_o[1]));
      end
      // Make the cell registered before its term feeds back on itself, so
      // no pin loop can form while the fuses are written.
      wr(12'h010, 32'h01);
      fuse(25, lit(28));
      fuse(OE_BASE + 2, 44'h0);
      fuse(AR_IDX, lit(20));
      fuse(SP_IDX, lit(18));
      ded_in_i <= 12'h000;
      for (int k = 0; k < 4; k++) begin
         b = io_o[2];
         @(posedge mclk_i);
         chk("toggle", 44'({1'b0, ~b}),
             44'({io_oe_n_o[2], io_o[2]}));
      end
      ded_in_i <= 12'h600;
      #1;
      chk("async clear", 44'h0, 44'(io_o[2]));
      repeat (2) @(posedge mclk_i);
      chk("clear over preset", 44'h0, 44'(io_o[2]));
      rdr(STAT_OFS);
      chk("cleared status", 44'h400, 44'({rd[20], rd[9:0]}));
      ded_in_i <= 12'h200;
      repeat (2) @(posedge mclk_i);
      chk("preset", 44'h1, 44'(io_o[2]));
      wr(12'h010, 32'h00);
      chk("inverted preset", 44'h0, 44'(io_o[2]));
      ded_in_i <= 12'h400;
      @(posedge mclk_i);
      chk("inverted clear", 44'h1, 44'(io_o[2]));
      ded_in_i <= 12'h000;
      sig = $random(seed);
      wr(SIG_OFS, sig);
      rdr(SIG_OFS);
      chk("signature", 44'(sig), 44'(rd));
      for (int i = 0; i < 18; i++) tck_cyc(TMS_SEQ[i], TDI_SEQ[i]);
      for (int i = 0; i < 32; i++) begin
         tck_cyc(i == 31, 1'b0);
         rd[i] = b;
         if (i == 0) begin
            chk("tdo enable", 44'h0, 44'(tdo_oe_n_o));
         end
      end
      chk("user code", 44'(sig), 44'(rd));
      end_sim;
   end
endmodule
